// *** design/cip_top.v ***
// capture three-to-five interrupt priority register with avalon-mm slave
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "cip_regs.vh"
module cip_top (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // avalon-mm slave
  input wire [`CIP_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // capture flags in, request to the core out
  input wire [2:0] capture_flag,
  output reg irq_req,
  output reg [2:0] irq_level,
  output reg [1:0] irq_source
);
  // bus handshake states: idle waits for a request, answer drops waitrequest
  localparam BUS_IDLE = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  // the priority register and the bus state
  reg [15:0] capture_three_to_five_priority;
  reg bus_state;

  // next values worked out by the combinational processes
  reg next_bus_state;
  reg next_waitrequest;
  reg [31:0] next_readdata;
  reg next_irq_req;
  reg [2:0] next_irq_level;
  reg [1:0] next_irq_source;

  // per-channel views of the register
  wire [2:0] capture5_irq_level;
  wire [2:0] capture4_irq_level;
  wire [2:0] capture3_irq_level;
  wire [8:0] chan_levels;
  wire [2:0] chan_enabled;
  wire [2:0] chan_pending;

  // arbiter result
  wire [2:0] win_level;
  wire [1:0] win_idx;
  wire win_valid;

  // bus decode and write data
  wire req;
  wire accept;
  wire hit_prio;
  wire prio_write;
  wire data_read;
  wire [15:0] wmask;
  wire [15:0] keep_bits;
  wire [15:0] write_bits;
  wire [15:0] next_prio;
  wire [31:0] status_word;
  // loop index shared by the per-channel and per-lane loops
  genvar g;

  assign capture5_irq_level = capture_three_to_five_priority[`CIP_C5_HI:`CIP_C5_LO];
  assign capture4_irq_level = capture_three_to_five_priority[`CIP_C4_HI:`CIP_C4_LO];
  // channel three field, laid out like the other two
  assign capture3_irq_level = capture_three_to_five_priority[`CIP_C3_HI:`CIP_C3_LO];
  assign chan_levels = {capture5_irq_level, capture4_irq_level, capture3_irq_level};

  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_chan
      wire [2:0] lvl;
      assign lvl = chan_levels[g*3 +: 3];
      assign chan_enabled[g] = (lvl != `CIP_LEVEL_OFF);
      assign chan_pending[g] = capture_flag[g] & chan_enabled[g];
    end
  endgenerate

  // one byte enable per lane of the low half-word; upper lanes hold nothing
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_lane
      assign wmask[g*8 +: 8] = {8{avs_byteenable[g]}};
    end
  endgenerate

  // a request is taken only in idle, so a held request is not taken twice
  assign req = avs_read | avs_write;
  assign accept = req & (bus_state == BUS_IDLE);
  assign hit_prio = (avs_address == `CIP_OFF_PRIO);
  assign prio_write = accept & avs_write & hit_prio;
  assign data_read = accept & avs_read;

  // only implemented bits take write data
  assign keep_bits = capture_three_to_five_priority & ~wmask & `CIP_PRIO_MASK;
  assign write_bits = avs_writedata[15:0] & wmask & `CIP_PRIO_MASK;
  assign next_prio = keep_bits | write_bits;

  // status word: request, level and source of the current winner
  assign status_word = {26'h0, irq_req, irq_level, irq_source};

  cip_arbiter u_arb (
    .pending(chan_pending),
    .levels(chan_levels),
    .winner_level(win_level),
    .winner_idx(win_idx),
    .winner_valid(win_valid)
  );

  // next bus state: one wait state, then waitrequest low for one cycle
  always @* begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ANSWER;
          next_waitrequest = 1'b0;
        end
      end
      // a held request is answered once
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      // stray code returns to idle
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // bus state and waitrequest registers
  always @(posedge clk_sys) begin
    if (rst) begin
      // waitrequest high out of reset, so nothing is answered early
      bus_state <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // register write: lands at the edge that takes the request
  always @(posedge clk_sys) begin
    if (rst) begin
      capture_three_to_five_priority <= `CIP_PRIO_RST;
    end else begin
      // a write to any other place is dropped
      if (prio_write) begin
        capture_three_to_five_priority <= next_prio;
      end
    end
  end

  // read data: picked at the taking edge and held until the next read
  always @* begin
    next_readdata = avs_readdata;
    if (data_read) begin
      case (avs_address)
        `CIP_OFF_PRIO: begin
          next_readdata = {16'h0, capture_three_to_five_priority};
        end
        `CIP_OFF_STATUS: begin
          next_readdata = status_word;
        end
        // unmapped places read zero
        default: begin
          next_readdata = 32'h0;
        end
      endcase
    end
  end

  // read data register
  always @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else begin
      // the word stands until the next read is taken
      avs_readdata <= next_readdata;
    end
  end

  // next request to the core; flags are same-clock logic, so no synchroniser
  always @* begin
    next_irq_req = win_valid;
    // no winner reports level zero and channel three
    next_irq_level = `CIP_LEVEL_OFF;
    next_irq_source = 2'h0;
    if (win_valid) begin
      next_irq_level = win_level;
      next_irq_source = win_idx;
    end
  end

  // registered request outputs, one cycle behind the flags
  always @(posedge clk_sys) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_level <= 3'h0;
      irq_source <= 2'h0;
    end else begin
      irq_req <= next_irq_req;
      irq_level <= next_irq_level;
      irq_source <= next_irq_source;
    end
  end
endmodule

// *** design/cip_regs.vh ***
// register offsets, field positions, reset values for the capture priority register
`ifndef CIP_REGS_VH
`define CIP_REGS_VH
`define CIP_ADDR_W 4
`define CIP_OFF_PRIO 4'h0
`define CIP_OFF_STATUS 4'h4
`define CIP_C5_HI 14
`define CIP_C5_LO 12
`define CIP_C4_HI 10
`define CIP_C4_LO 8
`define CIP_C3_HI 6
`define CIP_C3_LO 4
`define CIP_LEVEL_RST 3'h4
`define CIP_LEVEL_OFF 3'h0
`define CIP_PRIO_MASK 16'h7770
`define CIP_PRIO_RST 16'h4440
`endif

// *** design/cip_arbiter.v ***
// picks the highest-level pending capture source among channels three to five
`timescale 1ns/10ps
`include "cip_regs.vh"
module cip_arbiter (
  input wire [2:0] pending,
  input wire [8:0] levels,
  output reg [2:0] winner_level,
  output reg [1:0] winner_idx,
  output reg winner_valid
);
  integer i;
  reg [2:0] lvl;
  // a level of zero never wins; ties go to the lower channel
  always @* begin
    winner_level = `CIP_LEVEL_OFF;
    winner_idx = 2'h0;
    winner_valid = 1'b0;
    lvl = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      lvl = levels[i*3 +: 3];
      if (pending[i] && (lvl != `CIP_LEVEL_OFF) && (lvl > winner_level)) begin
        winner_level = lvl;
        winner_idx = i[1:0];
        winner_valid = 1'b1;
      end
    end
  end
endmodule

// *** dv/cip_top_monitor.sv ***
// port assertions for the capture priority register
`timescale 1ns/10ps
module cip_monitor (
  input wire clk_sys,
  input wire rst,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [2:0] capture_flag,
  input wire irq_req,
  input wire [2:0] irq_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // reset itself is checked, so it must not disable this one
  a_reset_clears: assert property (disable iff (1'h0) rst |=> avs_waitrequest && !irq_req)
    else $error("reset");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  a_unused_zero: assert property ((avs_readdata & 32'hffff8880) == 32'h0)
    else $error("unused bits");
  a_flag_needed: assert property (capture_flag == 3'h0 |=> !irq_req) else $error("req");
  a_level_live: assert property (irq_req |-> irq_level != 3'h0) else $error("level");
  a_level_idle: assert property (!irq_req |-> irq_level == 3'h0) else $error("idle");
endmodule
bind cip_top cip_monitor mon (.clk_sys(clk_sys), .rst(rst), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .capture_flag(capture_flag), .irq_req(irq_req),
  .irq_level(irq_level));

// *** dv/testbench.sv ***
// bench for the capture priority register
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, busy;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q, rdata;
  logic [2:0] flag = 3'h0;
  int failures = 0, tests_run = 0;
  cip_top dut (.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(busy),
    .capture_flag(flag), .irq_req(), .irq_level(), .irq_source());
  initial forever #10 clk_sys = ~clk_sys;
  // one bus access; holds the request until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    do @(posedge clk_sys); while (busy !== 1'h0);
    q = rdata;
    {wr, rd} <= 2'h0;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("%0d checks, %0d failures", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence: reset value, masking, unmapped place, arbitration
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    acc(1'h0, 4'h0, 32'h0);
    check(q, 32'h4440);
    acc(1'h1, 4'h0, 32'hffff);
    acc(1'h0, 4'h0, 32'h0);
    check(q, 32'h7770);
    acc(1'h1, 4'h0, 32'h2710);
    acc(1'h0, 4'h0, 32'h0);
    check(q, 32'h2710);
    acc(1'h1, 4'h8, 32'hffff);
    acc(1'h0, 4'h8, 32'h0);
    check(q, 32'h0);
    acc(1'h1, 4'h0, 32'h0710);
    flag <= 3'h7;
    acc(1'h0, 4'h4, 32'h0);
    check(q, 32'h3d);
    flag <= 3'h4;
    acc(1'h0, 4'h4, 32'h0);
    check(q, 32'h0);
    finish_test;
  end
  // tests need well under a hundred cycles
  initial begin
    repeat (1000) @(posedge clk_sys);
    failures++;
    finish_test;
  end
endmodule
